// ==== hw/fdp_rom.sv ====
// Flash discovery parameter ROM with a local register port.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns

`include "fdp_consts.svh"

module fdp_rom
  import fdp_pkg::*;
#(
  parameter bit LARGE_BLOCK = 1'b0
) (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port.
  input  wire fdp_req_type req_i,
  output fdp_rsp_type      rsp_o
);

  logic [3:0]  dword_idx;
  logic [5:0]  dword_off;
  logic        in_table;
  logic [31:0] dword_val;
  logic [7:0]  byte_val;
  logic [7:0]  rd_data_d;
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic        wr_seen_q;
  logic        stat_sel;
  logic [31:0] rom_q [16];

  // Table contents; the option is fixed at build time so no byte can move.
  function automatic logic [31:0] table_dword(input logic [3:0] idx);
    logic [31:0] v;
    v = `FDP_BLANK_WORD;
    unique case (idx)
      `FDP_DW_CAPS: begin
        v = {`FDP_RESERVED_BYTE,
             `FDP_SUPPORTED,
             `FDP_SUPPORTED,
             `FDP_SUPPORTED,
             `FDP_SUPPORTED,
             `FDP_SUPPORTED,
             `FDP_ADDR_3_AND_4,
             `FDP_SUPPORTED,
             `FDP_ERASE_4K_OP,
             `FDP_UNUSED3,
             `FDP_WREN_SELECT,
             `FDP_VOL_BP_BITS,
             `FDP_WR_GRAN_64,
             `FDP_MIN_ERASE_CODE};
      end
      `FDP_DW_DENSITY: begin
        v = `FDP_DENSITY;
      end
      `FDP_DW_QUAD_RD: begin
        v = {`FDP_OP_114, `FDP_MODE_114, `FDP_WAIT_114,
             `FDP_OP_144, `FDP_MODE_144, `FDP_WAIT_144};
      end
      `FDP_DW_DUAL_RD: begin
        v = {`FDP_OP_122, `FDP_MODE_122, `FDP_WAIT_122,
             `FDP_OP_112, `FDP_MODE_112, `FDP_WAIT_112};
      end
      `FDP_DW_WIDE_CAPS: begin
        v = {`FDP_RESERVED_3B,
             `FDP_UNUSED3,
             `FDP_SUPPORTED,
             `FDP_UNUSED3,
             `FDP_UNSUPPORTED};
      end
      `FDP_DW_222_RD: begin
        v = {`FDP_OP_222, `FDP_MODE_222, `FDP_WAIT_222,
             `FDP_RESERVED_HALF};
      end
      `FDP_DW_444_RD: begin
        v = {`FDP_OP_444, `FDP_MODE_444, `FDP_WAIT_444,
             `FDP_RESERVED_HALF};
      end
      `FDP_DW_ERASE_A: begin
        v = {`FDP_T2_OP, `FDP_T2_SIZE,
             `FDP_T1_OP, `FDP_T1_SIZE};
      end
      `FDP_DW_ERASE_B: begin
        if (LARGE_BLOCK) begin
          v = {`FDP_T4_OP_LB, `FDP_T4_SIZE_LB,
               `FDP_ABSENT_OP, `FDP_ABSENT_SIZE};
        end else begin
          v = {`FDP_ABSENT_OP, `FDP_ABSENT_SIZE,
               `FDP_T3_OP, `FDP_T3_SIZE};
        end
      end
      `FDP_DW_ERASE_TIME: begin
        if (LARGE_BLOCK) begin
          v = {`FDP_T4_UNIT_LB, `FDP_T4_CNT_LB,
               `FDP_ZERO_UNIT, `FDP_ZERO_CNT,
               `FDP_T2_UNIT, `FDP_T2_CNT,
               `FDP_T1_UNIT, `FDP_T1_CNT,
               `FDP_ERASE_MULT};
        end else begin
          v = {`FDP_ZERO_UNIT, `FDP_ZERO_CNT,
               `FDP_T3_UNIT, `FDP_T3_CNT,
               `FDP_T2_UNIT, `FDP_T2_CNT,
               `FDP_T1_UNIT, `FDP_T1_CNT,
               `FDP_ERASE_MULT};
        end
      end
      default: begin
        v = `FDP_BLANK_WORD;
      end
    endcase
    return v;
  endfunction

  // Locate the dword from the table pointer and the table length.
  assign dword_off = req_i.addr[7:2] - `FDP_BASE_DWORD;
  assign dword_idx = dword_off[3:0];
  assign in_table  = (req_i.addr >= `FDP_TABLE_BASE) &&
                     ({1'b0, dword_off} < {1'b0, `FDP_TABLE_DWORDS});
  assign stat_sel  = (req_i.addr == `FDP_STAT_ADDR);
  assign dword_val = rom_q[dword_idx];

  // Table image held in flip-flops, loaded with fixed values by reset and
  // never written afterwards, so no location can change at run time.
  for (genvar g = 0; g < 16; g++) begin : g_rom
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rom_q[g] <= table_dword(4'(g));
      end else begin
        rom_q[g] <= rom_q[g];
      end
    end
  end

  // Lowest byte address holds bits 7:0 of each dword.
  always_comb begin
    unique case (req_i.addr[1:0])
      2'h0:    byte_val = dword_val[7:0];
      2'h1:    byte_val = dword_val[15:8];
      2'h2:    byte_val = dword_val[23:16];
      default: byte_val = dword_val[31:24];
    endcase
  end

  // Anything outside the table except the status register reads as erased flash.
  always_comb begin
    if (stat_sel) begin
      rd_data_d = {7'h00, wr_seen_q};
    end else if (in_table) begin
      rd_data_d = byte_val;
    end else begin
      rd_data_d = `FDP_BLANK_BYTE;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q  <= `FDP_RESET_DATA;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req_i.rd;
      if (req_i.rd) begin
        rd_data_q <= rd_data_d;
      end else begin
        rd_data_q <= `FDP_RESET_DATA;
      end
    end
  end

  // Writes never alter the table; those off the status register are only recorded so software can
  // tell that a driver tried. A new write beats a clear in the same cycle,
  // which cannot happen anyway since a clear is itself a write.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_seen_q <= 1'b0;
    end else if (req_i.wr && !stat_sel) begin
      wr_seen_q <= 1'b1;
    end else if (req_i.wr && req_i.wdata[`FDP_STAT_WR_SEEN]) begin
      wr_seen_q <= 1'b0;
    end
  end

  assign rsp_o.data  = rd_data_q;
  assign rsp_o.valid = rd_valid_q;

endmodule

// ==== hw/fdp_consts.svh ====
// Constants for the flash discovery parameter ROM: map, fields and values.
`ifndef FDP_CONSTS_SVH
`define FDP_CONSTS_SVH

// Byte map of the basic table and of the local status register.
`define FDP_TABLE_BASE     8'h30
`define FDP_TABLE_DWORDS   5'h10
`define FDP_BASE_DWORD     6'h0c
`define FDP_STAT_ADDR      8'hf0
`define FDP_STAT_WR_SEEN   0
`define FDP_BLANK_BYTE     8'hff
`define FDP_BLANK_WORD     32'hffffffff
`define FDP_RESET_DATA     8'h00

// Dword indices within the table.
`define FDP_DW_CAPS        4'h0
`define FDP_DW_DENSITY     4'h1
`define FDP_DW_QUAD_RD     4'h2
`define FDP_DW_DUAL_RD     4'h3
`define FDP_DW_WIDE_CAPS   4'h4
`define FDP_DW_222_RD      4'h5
`define FDP_DW_444_RD      4'h6
`define FDP_DW_ERASE_A     4'h7
`define FDP_DW_ERASE_B     4'h8
`define FDP_DW_ERASE_TIME  4'h9

// First dword fields.
`define FDP_MIN_ERASE_CODE 2'b01
`define FDP_WR_GRAN_64     1'b1
`define FDP_VOL_BP_BITS    1'b0
`define FDP_WREN_SELECT    1'b0
`define FDP_UNUSED3        3'b111
`define FDP_ERASE_4K_OP    8'h20
`define FDP_ADDR_3_AND_4   2'b01
`define FDP_SUPPORTED      1'b1
`define FDP_UNSUPPORTED    1'b0
`define FDP_RESERVED_BYTE  8'hff
`define FDP_RESERVED_HALF  16'hffff
`define FDP_RESERVED_3B    24'hffffff

// Density: size in bits minus one.
`define FDP_DENSITY        32'h1fffffff

// Fast read opcodes, wait counts and mode-bit counts.
`define FDP_OP_144         8'heb
`define FDP_WAIT_144       5'b00100
`define FDP_MODE_144       3'b010
`define FDP_OP_114         8'h6b
`define FDP_WAIT_114       5'b01000
`define FDP_MODE_114       3'b000
`define FDP_OP_112         8'h3b
`define FDP_WAIT_112       5'b01000
`define FDP_MODE_112       3'b000
`define FDP_OP_122         8'hbb
`define FDP_WAIT_122       5'b00000
`define FDP_MODE_122       3'b100
`define FDP_OP_222         8'hff
`define FDP_WAIT_222       5'b00000
`define FDP_MODE_222       3'b000
`define FDP_OP_444         8'heb
`define FDP_WAIT_444       5'b00100
`define FDP_MODE_444       3'b010

// Erase types: size exponent and opcode.
`define FDP_T1_SIZE        8'h0c
`define FDP_T1_OP          8'h20
`define FDP_T2_SIZE        8'h0f
`define FDP_T2_OP          8'h52
`define FDP_T3_SIZE        8'h10
`define FDP_T3_OP          8'hd8
`define FDP_T4_SIZE_LB     8'h12
`define FDP_T4_OP_LB       8'hd8
`define FDP_ABSENT_SIZE    8'h00
`define FDP_ABSENT_OP      8'hff

// Typical erase times.
`define FDP_ERASE_MULT     4'b0010
`define FDP_T1_CNT         5'b00110
`define FDP_T1_UNIT        2'b01
`define FDP_T2_CNT         5'b01000
`define FDP_T2_UNIT        2'b01
`define FDP_T3_CNT         5'b01010
`define FDP_T3_UNIT        2'b01
`define FDP_T4_CNT_LB      5'b00101
`define FDP_T4_UNIT_LB     2'b10
`define FDP_ZERO_CNT       5'b00000
`define FDP_ZERO_UNIT      2'b00

`endif

// ==== hw/fdp_pkg.sv ====
// Types shared by the flash discovery parameter ROM and its users.
package fdp_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fdp_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } fdp_rsp_type;

endpackage

// ==== tb/fdp_host.sv ====
// Host controller model that issues register port reads and writes.
`timescale 1ns/1ns
module fdp_host
  import fdp_pkg::*;
(
  // Clock.
  input  wire logic  clock_i,
  // Request toward the ROM.
  output fdp_req_type req_o
);
  initial req_o = '0;

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    req_o <= '{addr: a, wdata: ~req_o.wdata, wr: 1'b0, rd: 1'b1};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask

  // Idle lines show no stale value, so a latch on them would be caught.
  task automatic idle();
    @(posedge clock_i);
    req_o <= '{addr: ~req_o.addr, wdata: ~req_o.wdata, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ==== tb/fdp_rom_monitor.sv ====
// Concurrent checks on the parameter ROM register port.
`timescale 1ns/1ns
module fdp_rom_monitor
  import fdp_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire fdp_req_type req_i,
  input wire fdp_rsp_type rsp_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd(logic [7:0] a);
    req_i.rd && req_i.addr == a;
  endsequence
  sequence s_wr_tab;
    req_i.wr && req_i.addr != 8'hf0;
  endsequence
  sequence s_clr;
    req_i.wr && req_i.addr == 8'hf0 && req_i.wdata[0];
  endsequence

  property p_ans; req_i.rd |=> rsp_o.valid; endproperty
  property p_quiet; !req_i.rd |=> !rsp_o.valid && rsp_o.data == 8'h00;
  endproperty
  property p_caps; s_rd(8'h30) |=> rsp_o.data == 8'he5; endproperty
  property p_modes; s_rd(8'h32) |=> rsp_o.data == 8'hfb; endproperty
  property p_dens; s_rd(8'h37) |=> rsp_o.data == 8'h1f; endproperty
  property p_qop; s_rd(8'h39) |=> rsp_o.data == 8'heb; endproperty
  property p_e1op; s_rd(8'h4d) |=> rsp_o.data == 8'h20; endproperty
  property p_rsv;
    req_i.rd && req_i.addr inside {8'h33, [8'h41:8'h45], 8'h48, 8'h49}
      |=> rsp_o.data == 8'hff;
  endproperty
  property p_set; s_wr_tab ##1 s_rd(8'hf0) |=> rsp_o.data == 8'h01;
  endproperty
  property p_clr; s_clr ##1 s_rd(8'hf0) |=> rsp_o.data == 8'h00;
  endproperty

  a_ans: assert property (p_ans) else $error("no answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_caps: assert property (p_caps) else $error("bad 30");
  a_modes: assert property (p_modes) else $error("bad 32");
  a_dens: assert property (p_dens) else $error("bad 37");
  a_qop: assert property (p_qop) else $error("bad 39");
  a_e1op: assert property (p_e1op) else $error("bad 4d");
  a_rsv: assert property (p_rsv) else $error("bad blank");
  a_set: assert property (p_set) else $error("flag unset");
  a_clr: assert property (p_clr) else $error("flag kept");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for both build options of the parameter ROM.
`timescale 1ns/1ns
module tb_top
  import fdp_pkg::*;
;
  localparam logic [0:39][7:0] STD = {64'he520fbffffffff1f,
    64'h44eb086b083b80bb, 64'hfeffffffffff00ff,
    64'hffff44eb0c200f52, 64'h10d800ff6242a900};
  localparam logic [0:7][7:0] LB = 64'h00ff12d86242018a;
  logic        clock_i;
  logic        rst_n_i;
  fdp_req_type req;
  fdp_rsp_type rsp_s;
  fdp_rsp_type rsp_l;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic        seen_q;
  logic [7:0]  lfsr;
  int          miscompares;
  int          cmp_count;
  int          cycles;

  fdp_host host (.clock_i(clock_i), .req_o(req));
  fdp_rom #(.LARGE_BLOCK(1'b0)) DUT (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp_s));
  fdp_rom #(.LARGE_BLOCK(1'b1)) DUT_lb (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp_l));

  function automatic logic [7:0] exp_b(input logic [7:0] a, input bit lb);
    if (a == 8'hf0) return {7'h00, seen_q};
    if (a < 8'h30 || a > 8'h57) return 8'hff;
    if (lb && a >= 8'h50) return LB[a - 8'h50];
    return STD[a - 8'h30];
  endfunction

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a);
    host.rd(a);
    exp_q.push_back({exp_b(a, 1'b1), exp_b(a, 1'b0)});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a != 8'hf0) seen_q = 1'b1;
    else if (d[0]) seen_q = 1'b0;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      end_sim();
    end
    if (rsp_s.valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 16'h0000;
      check(rsp_s.data, e[7:0]);
      check(rsp_l.data, e[15:8]);
      check({7'h00, rsp_l.valid}, 8'h01);
    end
  end

  initial begin
    rst_n_i = 1'b0;
    seen_q = 1'b0;
    lfsr = 8'd48;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(8'hf0);
    for (int a = 8'h2c; a <= 8'h73; a++) rd(a[7:0]);
    // A write into the table is refused but marks the status flag.
    wr(8'h40, 8'h00);
    rd(8'hf0);
    rd(8'h40);
    wr(8'hf0, 8'h00);
    rd(8'hf0);
    wr(8'hf0, 8'h01);
    rd(8'hf0);
    repeat (60) begin
      lfsr = lfsr_next(lfsr);
      if (lfsr[0]) rd(lfsr_next(lfsr));
      else wr(lfsr ^ 8'h5a, lfsr);
    end
    wr(8'h31, 8'h00);
    host.idle();
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b0;
    seen_q = 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(8'hf0);
    rd(8'h30);
    host.idle();
    repeat (4) @(posedge clock_i);
    check(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule

bind fdp_rom fdp_rom_monitor u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .req_i(req_i), .rsp_o(rsp_o));
